// *** cbc_top.sv ***
`timescale 1ns/100ps
// Function
// - With auto balancing on, evaluate balance conditions once per voltage scan.
// - At scan end, compute and store lowest and highest configured cell voltage.
// - Flag each cell above the lowest by more than the lower delta.
// - Any cell above lowest by more than upper delta sets failure, stops balancing.
// - Highest below minimum sets too-low and stops; clears above minimum plus 117mV.
// - Lowest above maximum sets too-high and stops; clears below maximum minus 117mV.
// - Only configured cells take part; absent cells are never auto-balanced.
// - Any number of flagged cells may balance at once.
// - Cell selection refreshed at each on-period start, held for the period.
// - Temperature outside the programmed window disables balancing.
// - All three enable bits zero means never balance automatically.
// - Charge-only mode: no balancing without charge current, except at full.
// - Discharge-only mode: no balancing without discharge current, except at full.
// - Both modes: balance with either current, never with none, except at full.
// - Enable needs exactly one current direction with its matching enable bit.
// - At-full bit with end of charge enables regardless of current direction.
// - Force-off input disables every cell output regardless of anything else.
// - Outside override, outputs drive only during on-timer; all off during off-timer.
// - Timer setting is 2-bit scale (us, ms, s, min) plus 10-bit count.
// - Host override bit stops automatic balancing.
// - In override, each bit of register 84h drives one cell output.
// - Outputs follow the manual pattern only once the output-enable bit is set.
// - Watchdog timeout forces all outputs off until communication resumes.
// - Override stays set after timeout; outputs may return when allowed.
module cbc_top
  import cbc_pkg::*;
(
  input  wire logic                        clk_in,
  input  wire logic                        srst_in,
  input  wire logic                        scan_done_in,
  input  wire logic [NUM_CELLS*VOLT_W-1:0] cell_volt_in,
  input  wire logic [COUNT_W-1:0]          cell_count_in,
  input  wire logic [VOLT_W-1:0]           balance_lower_delta_in,
  input  wire logic [VOLT_W-1:0]           balance_upper_delta_in,
  input  wire logic [VOLT_W-1:0]           balance_min_voltage_in,
  input  wire logic [VOLT_W-1:0]           balance_max_voltage_in,
  input  wire logic [NUM_TEMPS*VOLT_W-1:0] temp_reading_in,
  input  wire logic [VOLT_W-1:0]           balance_low_temp_limit_in,
  input  wire logic [VOLT_W-1:0]           balance_high_temp_limit_in,
  input  wire logic                        balance_in_charge_enable_in,
  input  wire logic                        balance_in_discharge_enable_in,
  input  wire logic                        balance_at_full_enable_in,
  input  wire logic                        charging_detected_in,
  input  wire logic                        discharging_detected_in,
  input  wire logic                        end_of_charge_in,
  input  wire logic                        force_outputs_off_in,
  input  wire logic [TIMER_W-1:0]          balance_on_period_in,
  input  wire logic [TIMER_W-1:0]          balance_off_period_in,
  input  wire logic                        host_balance_override_in,
  input  wire logic                        manual_balance_output_enable_in,
  input  wire logic                        i2c_watchdog_timeout_in,
  input  wire logic                        reg_wr_in,
  input  wire logic [7:0]                  reg_addr_in,
  input  wire logic [7:0]                  reg_wdata_in,
  output logic      [7:0]                  reg_rdata_out,
  output logic      [NUM_CELLS-1:0]        cell_balance_out,
  output logic                             balance_on_phase_out,
  output logic      [VOLT_W-1:0]           lowest_cell_voltage_out,
  output logic      [VOLT_W-1:0]           highest_cell_voltage_out,
  output logic      [NUM_CELLS-1:0]        cell_needs_balance_flag_out,
  output logic                             cell_imbalance_fail_flag_out,
  output logic                             balance_too_low_flag_out,
  output logic                             balance_too_high_flag_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  cbc_tick_if tick_bus ();

  cbc_phase_t           phase_r;
  cbc_phase_t           phase_nxt;
  logic [PERIOD_W-1:0]  cnt_r;
  logic [PERIOD_W-1:0]  cnt_nxt;
  logic [NUM_CELLS-1:0] sel_r;
  logic [NUM_CELLS-1:0] sel_nxt;
  logic [NUM_CELLS-1:0] manual_r;
  logic [NUM_CELLS-1:0] out_nxt;
  logic [7:0]           rdata_nxt;
  logic                 auto_active;
  logic                 eval_update;
  logic                 any_mode;
  logic                 eoc_enable;
  logic                 dir_enable;
  logic                 bal_enable;
  logic [NUM_TEMPS-1:0] temp_in_window;
  logic                 temp_ok;
  logic                 auto_gate;
  logic                 kill;
  logic [NUM_CELLS-1:0] auto_drive;
  logic [NUM_CELLS-1:0] manual_drive;
  logic [PERIOD_W-1:0]  on_count;
  logic [PERIOD_W-1:0]  off_count;
  logic [SCALE_W-1:0]   on_scale;
  logic [SCALE_W-1:0]   off_scale;
  logic [SCALE_W-1:0]   run_scale;
  logic                 run_tick;
  logic                 cnt_zero;
  logic                 manual_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules

  cbc_tick_gen u_tick (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .tk      (tick_bus)
  );

  cbc_scan_eval u_eval (
    .clk_in         (clk_in),
    .srst_in        (srst_in),
    .update_in      (eval_update),
    .cell_volt_in   (cell_volt_in),
    .cell_count_in  (cell_count_in),
    .lower_delta_in (balance_lower_delta_in),
    .upper_delta_in (balance_upper_delta_in),
    .min_voltage_in (balance_min_voltage_in),
    .max_voltage_in (balance_max_voltage_in),
    .lowest_out     (lowest_cell_voltage_out),
    .highest_out    (highest_cell_voltage_out),
    .needs_out      (cell_needs_balance_flag_out),
    .fail_out       (cell_imbalance_fail_flag_out),
    .too_low_out    (balance_too_low_flag_out),
    .too_high_out   (balance_too_high_flag_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Balance permission

  assign any_mode    = balance_in_charge_enable_in | balance_in_discharge_enable_in
                     | balance_at_full_enable_in;
  assign auto_active = !host_balance_override_in && any_mode;
  assign eval_update = scan_done_in && auto_active;
  assign eoc_enable  = balance_at_full_enable_in && end_of_charge_in;
  assign dir_enable  = (charging_detected_in ^ discharging_detected_in)
                     && ((charging_detected_in && balance_in_charge_enable_in)
                     || (discharging_detected_in && balance_in_discharge_enable_in));
  assign bal_enable  = eoc_enable || dir_enable;

  // Readings are thermistor voltages: hotter reads lower
  genvar ti;
  generate
    for (ti = 0; ti < NUM_TEMPS; ti++) begin : g_temp
      logic [VOLT_W-1:0] t;
      assign t = temp_reading_in[ti*VOLT_W +: VOLT_W];
      assign temp_in_window[ti] = (t <= balance_low_temp_limit_in)
                               && (t >= balance_high_temp_limit_in);
    end
  endgenerate

  assign temp_ok   = &temp_in_window;
  assign auto_gate = bal_enable && temp_ok && !cell_imbalance_fail_flag_out
                  && !balance_too_low_flag_out && !balance_too_high_flag_out;

  ////////////////////////////////////////////////////////////////////////////////
  // On/off period timer

  assign on_count  = balance_on_period_in[PERIOD_LSB +: PERIOD_W];
  assign off_count = balance_off_period_in[PERIOD_LSB +: PERIOD_W];
  assign on_scale  = balance_on_period_in[SCALE_LSB +: SCALE_W];
  assign off_scale = balance_off_period_in[SCALE_LSB +: SCALE_W];
  assign run_scale = (phase_r == PH_ON) ? on_scale : off_scale;
  assign run_tick  = tick_bus.tick[run_scale];
  assign cnt_zero  = (cnt_r == '0);

  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt   = cnt_r;
    sel_nxt   = sel_r;
    if (!auto_active) begin
      phase_nxt = PH_IDLE;
      cnt_nxt   = '0;
      sel_nxt   = '0;
    end else begin
      case (phase_r)
        PH_IDLE: begin
          phase_nxt = PH_ON;
          cnt_nxt   = on_count;
          sel_nxt   = cell_needs_balance_flag_out;
        end
        PH_ON: begin
          if (cnt_zero) begin
            phase_nxt = PH_OFF;
            cnt_nxt   = off_count;
          end else if (run_tick) begin
            cnt_nxt = cnt_r - 10'h001;
          end
        end
        PH_OFF: begin
          if (cnt_zero) begin
            phase_nxt = PH_ON;
            cnt_nxt   = on_count;
            sel_nxt   = cell_needs_balance_flag_out;
          end else if (run_tick) begin
            cnt_nxt = cnt_r - 10'h001;
          end
        end
        default: begin
          phase_nxt = PH_IDLE;
          cnt_nxt   = '0;
          sel_nxt   = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output selection

  assign kill         = force_outputs_off_in || i2c_watchdog_timeout_in;
  // Every selected cell drives together, no count limit
  assign auto_drive   = (phase_r == PH_ON) ? (sel_r & {NUM_CELLS{auto_gate}})
                                           : '0;
  assign manual_drive = manual_balance_output_enable_in ? manual_r : '0;
  assign out_nxt      = kill ? '0
                      : host_balance_override_in ? manual_drive : auto_drive;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port

  assign manual_hit = (reg_addr_in == MANUAL_OUT_ADDR);
  assign rdata_nxt  = manual_hit ? manual_r : RDATA_UNMAPPED;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      manual_r <= MANUAL_OUT_RESET;
    end else if (reg_wr_in && manual_hit) begin
      manual_r <= reg_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State and outputs

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase_r              <= PH_IDLE;
      cnt_r                <= '0;
      sel_r                <= '0;
      cell_balance_out     <= '0;
      balance_on_phase_out <= 1'b0;
      reg_rdata_out        <= RDATA_UNMAPPED;
    end else begin
      phase_r              <= phase_nxt;
      cnt_r                <= cnt_nxt;
      sel_r                <= sel_nxt;
      cell_balance_out     <= out_nxt;
      balance_on_phase_out <= (phase_nxt == PH_ON);
      reg_rdata_out        <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_force_off_dark: assert property (force_outputs_off_in |=> cell_balance_out == '0)
    else $error("outputs on while forced off");
  a_watchdog_dark: assert property (i2c_watchdog_timeout_in |=> cell_balance_out == '0)
    else $error("outputs on during watchdog timeout");
  a_off_phase_dark: assert property (phase_r == PH_OFF && !host_balance_override_in
                                     |=> cell_balance_out == '0)
    else $error("outputs on during off period");
  a_sel_held_on: assert property (phase_r == PH_ON && $past(phase_r) == PH_ON
                                  |-> $stable(sel_r))
    else $error("selection changed within on period");
  a_on_reload: assert property (phase_r == PH_OFF && cnt_zero && auto_active
                                |=> phase_r == PH_ON && cnt_r == $past(on_count))
    else $error("on timer not reloaded after off period");
  a_no_mode_dark: assert property (!any_mode && !host_balance_override_in
                                   |=> cell_balance_out == '0 && phase_r == PH_IDLE)
    else $error("balancing with all modes disabled");
  a_both_dirs_off: assert property (charging_detected_in && discharging_detected_in
                                    && !eoc_enable && !host_balance_override_in
                                    |=> cell_balance_out == '0)
    else $error("balancing with both directions detected");
  a_fail_dark: assert property (cell_imbalance_fail_flag_out && !host_balance_override_in
                                |=> cell_balance_out == '0)
    else $error("balancing with failure flag set");
  a_temp_dark: assert property (!temp_ok && !host_balance_override_in
                                |=> cell_balance_out == '0)
    else $error("balancing outside temperature window");
  a_override_idle: assert property (host_balance_override_in |=> phase_r == PH_IDLE)
    else $error("automatic timer running under override");
  a_manual_drive: assert property (host_balance_override_in && manual_balance_output_enable_in
                                   && !kill |=> cell_balance_out == $past(manual_r))
    else $error("manual pattern not driven");
  a_manual_gated: assert property (host_balance_override_in && !manual_balance_output_enable_in
                                   |=> cell_balance_out == '0)
    else $error("manual outputs without enable");

  c_on_to_off: cover property (phase_r == PH_ON ##1 phase_r == PH_OFF);
  c_auto_drive: cover property (phase_r == PH_ON && auto_gate && sel_r != '0);
  c_full_balance: cover property (eoc_enable && !dir_enable ##1 cell_balance_out != '0);
  c_manual_on: cover property (host_balance_override_in ##1 cell_balance_out != '0);
endmodule // cbc_top

// *** cbc_pkg.sv ***
package cbc_pkg;
  localparam int NUM_CELLS = 8;
  localparam int VOLT_W    = 12;
  localparam int NUM_TEMPS = 2;
  localparam int PERIOD_W  = 10;
  localparam int SCALE_W   = 2;
  localparam int TIMER_W   = 12;
  localparam int COUNT_W   = 4;
  localparam int NUM_TICKS = 4;

  // Per-cell manual output register
  localparam logic [7:0] MANUAL_OUT_ADDR  = 8'h84;
  localparam logic [7:0] MANUAL_OUT_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

  // Timer setting layout: scale above a period count
  localparam int PERIOD_LSB = 0;
  localparam int SCALE_LSB  = 10;

  // Scale encodings, also the index into the tick bus
  localparam logic [1:0] SCALE_US  = 2'h0;
  localparam logic [1:0] SCALE_MS  = 2'h1;
  localparam logic [1:0] SCALE_S   = 2'h2;
  localparam logic [1:0] SCALE_MIN = 2'h3;

  // Timing
  localparam int CLK_HZ     = 125_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int US_PER_MS  = 1000;
  localparam int MS_PER_S   = 1000;
  localparam int S_PER_MIN  = 60;

  // Threshold hysteresis, 12-bit code = mV * 4095 * 3 / (1800 * 8)
  localparam int          HYST_MV   = 117;
  localparam logic [12:0] HYST_CODE = 13'(HYST_MV * 4095 * 3 / (1800 * 8));

  typedef enum logic [1:0] {PH_IDLE, PH_ON, PH_OFF} cbc_phase_t;
endpackage

// *** cbc_tick_if.sv ***
`timescale 1ns/100ps
interface cbc_tick_if;
  logic [3:0] tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

// *** cbc_tick_gen.sv ***
`timescale 1ns/100ps
module cbc_tick_gen
  import cbc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic srst_in,
  cbc_tick_if.src   tk
);
  logic [6:0] us_cnt_r;
  logic [9:0] ms_cnt_r;
  logic [9:0] s_cnt_r;
  logic [5:0] min_cnt_r;
  logic [3:0] tick_r;
  logic       us_wrap;
  logic       ms_wrap;
  logic       s_wrap;
  logic       min_wrap;

  assign us_wrap  = (us_cnt_r == 7'(CYC_PER_US - 1));
  assign ms_wrap  = us_wrap && (ms_cnt_r == 10'(US_PER_MS - 1));
  assign s_wrap   = ms_wrap && (s_cnt_r == 10'(MS_PER_S - 1));
  assign min_wrap = s_wrap && (min_cnt_r == 6'(S_PER_MIN - 1));
  assign tk.tick  = tick_r;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      us_cnt_r  <= '0;
      ms_cnt_r  <= '0;
      s_cnt_r   <= '0;
      min_cnt_r <= '0;
      tick_r    <= '0;
    end else begin
      us_cnt_r  <= us_wrap ? '0 : us_cnt_r + 7'h01;
      if (us_wrap) ms_cnt_r  <= ms_wrap ? '0 : ms_cnt_r + 10'h001;
      if (ms_wrap) s_cnt_r   <= s_wrap ? '0 : s_cnt_r + 10'h001;
      if (s_wrap)  min_cnt_r <= min_wrap ? '0 : min_cnt_r + 6'h01;
      tick_r    <= {min_wrap, s_wrap, ms_wrap, us_wrap};
    end
  end
endmodule // cbc_tick_gen

// *** cbc_scan_eval.sv ***
`timescale 1ns/100ps
module cbc_scan_eval
  import cbc_pkg::*;
(
  input  wire logic                        clk_in,
  input  wire logic                        srst_in,
  input  wire logic                        update_in,
  input  wire logic [NUM_CELLS*VOLT_W-1:0] cell_volt_in,
  input  wire logic [COUNT_W-1:0]          cell_count_in,
  input  wire logic [VOLT_W-1:0]           lower_delta_in,
  input  wire logic [VOLT_W-1:0]           upper_delta_in,
  input  wire logic [VOLT_W-1:0]           min_voltage_in,
  input  wire logic [VOLT_W-1:0]           max_voltage_in,
  output logic      [VOLT_W-1:0]           lowest_out,
  output logic      [VOLT_W-1:0]           highest_out,
  output logic      [NUM_CELLS-1:0]        needs_out,
  output logic                             fail_out,
  output logic                             too_low_out,
  output logic                             too_high_out
);
  logic [VOLT_W-1:0]    min_chain [NUM_CELLS+1];
  logic [VOLT_W-1:0]    max_chain [NUM_CELLS+1];
  logic [NUM_CELLS-1:0] present;
  logic [NUM_CELLS-1:0] over_lower;
  logic [NUM_CELLS-1:0] over_upper;
  logic [VOLT_W-1:0]    cur_min;
  logic [VOLT_W-1:0]    cur_max;
  logic                 uv_nxt;
  logic                 ov_nxt;

  assign min_chain[0] = {VOLT_W{1'b1}};
  assign max_chain[0] = '0;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
      logic [VOLT_W-1:0] v;
      logic [VOLT_W-1:0] diff;
      assign v  = cell_volt_in[gi*VOLT_W +: VOLT_W];
      assign present[gi] = (COUNT_W'(gi) < cell_count_in);
      assign min_chain[gi+1] = (present[gi] && v < min_chain[gi]) ? v : min_chain[gi];
      assign max_chain[gi+1] = (present[gi] && v > max_chain[gi]) ? v : max_chain[gi];
      assign diff = v - cur_min;
      assign over_lower[gi] = present[gi] && (diff > lower_delta_in);
      assign over_upper[gi] = present[gi] && (diff > upper_delta_in);
    end
  endgenerate

  assign cur_min = min_chain[NUM_CELLS];
  assign cur_max = max_chain[NUM_CELLS];
  // Hysteresis: set below / above threshold, clear only past the band
  assign uv_nxt = too_low_out ? ({1'b0, cur_max} <= {1'b0, min_voltage_in} + HYST_CODE)
                              : (cur_max < min_voltage_in);
  assign ov_nxt = too_high_out ? ({1'b0, cur_min} + HYST_CODE >= {1'b0, max_voltage_in})
                               : (cur_min > max_voltage_in);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lowest_out   <= '0;
      highest_out  <= '0;
      needs_out    <= '0;
      fail_out     <= 1'b0;
      too_low_out  <= 1'b0;
      too_high_out <= 1'b0;
    end else if (update_in) begin
      lowest_out   <= cur_min;
      highest_out  <= cur_max;
      needs_out    <= over_lower;
      fail_out     <= |over_upper;
      too_low_out  <= uv_nxt;
      too_high_out <= ov_nxt;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_absent_not_flagged: assert property (update_in |=> (needs_out & ~$past(present)) == '0)
    else $error("absent cell flagged for balance");
  a_uv_sets: assert property (update_in && !too_low_out && cur_max < min_voltage_in
                              |=> too_low_out)
    else $error("too-low flag not set");
  a_ov_sets: assert property (update_in && !too_high_out && cur_min > max_voltage_in
                              |=> too_high_out)
    else $error("too-high flag not set");
  a_min_not_above_max: assert property (update_in && cell_count_in != '0
                                        |=> lowest_out <= highest_out)
    else $error("lowest above highest");
endmodule // cbc_scan_eval

// *** cbc_host_model.sv ***
`timescale 1ns/100ps
module cbc_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic            reg_wr_out = 1'b0,
  output logic      [7:0] reg_addr_out = 8'h00,
  output logic      [7:0] reg_wdata_out = 8'h00,
  output logic            override_out = 1'b0,
  output logic            out_enable_out = 1'b0
);
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_addr_out <= a;
    @(posedge clk_in);
    #1 d = reg_rdata_in;
  endtask
  task automatic set_ctl(input logic ov, input logic en);
    @(posedge clk_in);
    override_out <= ov;
    out_enable_out <= en;
  endtask
endmodule // cbc_host_model

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top
  import cbc_pkg::*;
;
  logic        clk_in = 1'b0, srst_in = 1'b1, sd = 1'b0;
  logic [95:0] cv = '0;
  logic [23:0] tr = {12'h7D0, 12'h7D0};
  logic        cen = 1'b1, den = 1'b0, fen = 1'b0, chg = 1'b1, dch = 1'b0;
  logic        eoc = 1'b0, fo = 1'b0, wd = 1'b0;
  logic [7:0]  d;
  logic [3:0]  cc = 4'h4;
  logic [11:0] ld = 12'h01E, onp = 12'h014, offp = 12'h004;
  wire         wr, ov, me, ph, fl, lo, hi;
  wire  [7:0]  ad, wdt, rd, cbo, nd;
  wire  [11:0] lv, hv;
  int          failures = 0, checked = 0, n;
  logic [6:0]  tb[10] = '{7'h49, 7'h40, 7'h4C, 7'h25, 7'h28, 7'h60, 7'h65, 7'h53, 7'h50,
                          7'h49};
  logic [11:0] sv[6] = '{12'h190, 12'h226, 12'h28A, 12'hC1C, 12'hB86, 12'hAF0};
  logic [1:0]  sf[6] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0};
  always #4 clk_in = ~clk_in;
  cbc_host_model i_cbc_host_model (.clk_in(clk_in), .reg_rdata_in(rd), .reg_wr_out(wr),
    .reg_addr_out(ad), .reg_wdata_out(wdt), .override_out(ov), .out_enable_out(me));
  cbc_top i_cbc_top (.clk_in(clk_in), .srst_in(srst_in), .scan_done_in(sd), .cell_volt_in(cv),
    .cell_count_in(cc), .balance_lower_delta_in(ld), .balance_upper_delta_in(12'h1F4),
    .balance_min_voltage_in(12'h1F4), .balance_max_voltage_in(12'hBB8), .temp_reading_in(tr),
    .balance_low_temp_limit_in(12'hBB8), .balance_high_temp_limit_in(12'h3E8),
    .balance_in_charge_enable_in(cen), .balance_in_discharge_enable_in(den),
    .balance_at_full_enable_in(fen), .charging_detected_in(chg), .discharging_detected_in(dch),
    .end_of_charge_in(eoc), .force_outputs_off_in(fo), .balance_on_period_in(onp),
    .balance_off_period_in(offp), .host_balance_override_in(ov),
    .manual_balance_output_enable_in(me), .i2c_watchdog_timeout_in(wd), .reg_wr_in(wr),
    .reg_addr_in(ad), .reg_wdata_in(wdt), .reg_rdata_out(rd), .cell_balance_out(cbo),
    .balance_on_phase_out(ph), .lowest_cell_voltage_out(lv), .highest_cell_voltage_out(hv),
    .cell_needs_balance_flag_out(nd), .cell_imbalance_fail_flag_out(fl),
    .balance_too_low_flag_out(lo), .balance_too_high_flag_out(hi));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_span(input int got, input int lo_b, input int hi_b);
    checked++;
    if (got < lo_b || got > hi_b) begin
      failures++;
      $display("mismatch at %0t: span %0d outside %0d..%0d", $time, got, lo_b, hi_b);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic scan(input logic [11:0] c3, c2, c1, c0);
    @(posedge clk_in);
    cv <= {{4{12'hFA0}}, c3, c2, c1, c0};
    sd <= 1'b1;
    @(posedge clk_in);
    sd <= 1'b0;
    cyc(1);
  endtask
  task automatic wait_ph(input logic v);
    n = 0;
    while (ph !== v && n < 4000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    #1;
  endtask
  task automatic drive(input logic [23:0] t, input logic f, input logic w, input logic [11:0] e);
    @(posedge clk_in);
    tr <= t;
    fo <= f;
    wd <= w;
    cyc(3);
    chk(12'(cbo), e);
  endtask
  task automatic final_report();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    failures++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    cyc(1);
    chk({4'h0, cbo}, 12'h000);
    scan(12'h3F2, 12'h4B0, 12'h41A, 12'h3E8);
    chk(lv, 12'h3E8);
    chk(hv, 12'h4B0);
    chk(12'(nd), 12'h006);
    wait_ph(1'b0);
    wait_ph(1'b1);
    cyc(2);
    chk(12'(cbo), 12'h006);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      {cen, den, fen, chg, dch, eoc} <= tb[i][6:1];
      cyc(3);
      chk(12'(cbo), tb[i][0] ? 12'h006 : 12'h000);
    end
    drive({12'h7D0, 12'h100}, 1'b0, 1'b0, 12'h000);
    drive({12'hC80, 12'h7D0}, 1'b0, 1'b0, 12'h000);
    drive({12'h7D0, 12'h7D0}, 1'b1, 1'b0, 12'h000);
    drive({12'h7D0, 12'h7D0}, 1'b0, 1'b1, 12'h000);
    drive({12'h7D0, 12'h7D0}, 1'b0, 1'b0, 12'h006);
    scan(12'h4B0, 12'h3F2, 12'h41A, 12'h3E8);
    chk(12'(nd), 12'h00A);
    chk(12'(cbo), 12'h006);
    @(posedge clk_in);
    onp  <= 12'h00A;
    offp <= 12'h002;
    wait_ph(1'b0);
    cyc(1);
    chk(12'(cbo), 12'h000);
    wait_ph(1'b1);
    chk_span(n, CYC_PER_US, 2 * CYC_PER_US + 3);
    cyc(1);
    chk(12'(cbo), 12'h00A);
    wait_ph(1'b0);
    chk_span(n, 9 * CYC_PER_US, 10 * CYC_PER_US + 3);
    scan(12'h3F2, 12'h640, 12'h41A, 12'h3E8);
    chk(12'(fl), 12'h001);
    wait_ph(1'b1);
    cyc(2);
    chk(12'(cbo), 12'h000);
    @(posedge clk_in);
    cc <= 4'h3;
    ld <= 12'h031;
    scan(12'h640, 12'h3F2, 12'h41A, 12'h3E8);
    chk(hv, 12'h41A);
    chk(12'(nd), 12'h002);
    chk(12'(fl), 12'h000);
    @(posedge clk_in);
    cc <= 4'h4;
    ld <= 12'h01E;
    for (int i = 0; i < 6; i++) begin
      scan(sv[i], sv[i], sv[i], sv[i]);
      chk({10'h000, lo, hi}, 12'(sf[i]));
    end
    i_cbc_host_model.set_ctl(1'b1, 1'b0);
    i_cbc_host_model.write(8'h84, 8'hA5);
    i_cbc_host_model.write(8'h10, 8'hFF);
    i_cbc_host_model.read(8'h84, d);
    chk(12'(d), 12'h0A5);
    i_cbc_host_model.read(8'h10, d);
    chk(12'(d), 12'h000);
    chk(12'(cbo), 12'h000);
    i_cbc_host_model.set_ctl(1'b1, 1'b1);
    cyc(2);
    chk(12'(cbo), 12'h0A5);
    drive({12'h7D0, 12'h7D0}, 1'b0, 1'b1, 12'h000);
    drive({12'h7D0, 12'h7D0}, 1'b0, 1'b0, 12'h0A5);
    i_cbc_host_model.set_ctl(1'b0, 1'b0);
    {cen, den, fen} <= 3'h0;
    cyc(3);
    chk({3'h0, ph, cbo}, 12'h000);
    final_report();
  end
endmodule // tb_top
